// File: logic/scs_top.sv
// system clock switching: source select, peripheral/cpu/ram clocks, failover,
// fast rc trim and calibration, millisecond tick, watch crystal clock
// assumes oscillator levels arrive asynchronously and are oversampled by clk_i;
// flash_busy_i comes from logic on clk_i
module scs_top
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [31:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // oscillators and status from the analog side
  input  wire logic                  fast_rc_osc_i,
  input  wire logic                  main_crystal_osc_i,
  input  wire logic                  crystal_ok_i,
  input  wire logic                  slow_rc_osc_i,
  input  wire logic                  slow_rc_on_i,
  input  wire logic                  watch_crystal_osc_i,
  // flash controller
  input  wire logic                  flash_busy_i,
  // clock tree and controls
  output logic                       sys_clk_o,
  output logic                       periph_clk_o,
  output logic                       cpu_clock_o,
  output logic                       ram_clk_o,
  output logic                       radio_clk_ok_o,
  output logic                       crystal_osc_en_o,
  output logic [SCS_TRIM_W-1:0]      fast_rc_trim_o,
  output logic                       millisecond_tick_clock_o,
  output logic                       watch_crystal_clock_o,
  output logic                       nmi_o
);

  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  sel);
    lane_merge = old_v;
    if (sel[0]) begin
      lane_merge[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      lane_merge[15:8] = new_v[15:8];
    end
  endfunction

  // input synchronisers: {watch, slow_on, slow, xtal_ok, xtal, fast}
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      prev_r  <= 6'h00;
    end else begin
      sync1_r <= {watch_crystal_osc_i, slow_rc_on_i, slow_rc_osc_i,
                  crystal_ok_i, main_crystal_osc_i, fast_rc_osc_i};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  logic fast_lvl;
  logic xtal_lvl;
  logic xtal_ok;
  logic slow_lvl;
  logic slow_on;
  logic fast_rise;
  logic xtal_rise;
  logic slow_rise;

  assign fast_lvl  = sync2_r[0];
  assign xtal_lvl  = sync2_r[1];
  assign xtal_ok   = sync2_r[2];
  assign slow_lvl  = sync2_r[3];
  assign slow_on   = sync2_r[4];
  assign fast_rise = fast_lvl & ~prev_r[0];
  assign xtal_rise = xtal_lvl & ~prev_r[1];
  assign slow_rise = slow_lvl & ~prev_r[3] & slow_on;

  // wishbone and register file
  logic [1:0]            main_src_r, main_src_nxt;
  logic                  cpu_sel_r, cpu_sel_nxt;
  logic [SCS_TRIM_W-1:0] trim_r, trim_nxt;
  logic [15:0]           tick_div_r, tick_div_nxt;
  logic                  failover_r, failover_nxt;
  logic                  nmi_r, nmi_nxt;
  logic                  ack_r, ack_nxt;
  logic [31:0]           dat_r, dat_nxt;
  logic [7:0]            cal_r;
  logic                  cur_xtal_r;
  logic                  cpu_sys_r;
  logic                  req;
  logic                  wr;
  logic                  want_xtal;
  logic                  fail_evt;
  logic [31:0]           rd_word;

  assign req       = wb_cyc_i & wb_stb_i;
  // a write lands at the edge where the master sees ack
  assign wr        = req & wb_we_i & ack_r;
  assign want_xtal = main_src_r[SCS_XSEL_BIT] & main_src_r[SCS_XEN_BIT] & xtal_ok;
  assign fail_evt  = cur_xtal_r & ~xtal_ok;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (wb_adr_i == SCS_MAIN_SRC_ADR) begin
      rd_word[1:0] = main_src_r;
    end else if (wb_adr_i == SCS_CPU_SEL_ADR) begin
      rd_word[SCS_CPU_FAST_BIT] = cpu_sel_r;
    end else if (wb_adr_i == SCS_TRIM_ADR) begin
      rd_word[SCS_TRIM_W-1:0] = trim_r;
    end else if (wb_adr_i == SCS_TICK_DIV_ADR) begin
      rd_word[15:0] = tick_div_r;
    end else if (wb_adr_i == SCS_STATUS_ADR) begin
      rd_word[SCS_ST_XTAL_ACT]  = cur_xtal_r;
      rd_word[SCS_ST_FAILOVER]  = failover_r;
      rd_word[SCS_ST_XTAL_OK]   = xtal_ok;
      rd_word[SCS_ST_FLASH_FRC] = flash_busy_i;
      rd_word[SCS_ST_CPU_FAST]  = cpu_sys_r;
    end else if (wb_adr_i == SCS_CAL_ADR) begin
      rd_word[7:0] = cal_r;
    end
  end

  always_comb begin
    ack_nxt      = req & ~ack_r;
    dat_nxt      = (req & ~ack_r) ? rd_word : dat_r;
    main_src_nxt = main_src_r;
    cpu_sel_nxt  = cpu_sel_r;
    trim_nxt     = trim_r;
    tick_div_nxt = tick_div_r;
    if (wr && wb_adr_i == SCS_MAIN_SRC_ADR && wb_sel_i[0]) begin
      main_src_nxt = wb_dat_i[1:0];
    end
    if (wr && wb_adr_i == SCS_CPU_SEL_ADR && wb_sel_i[0]) begin
      cpu_sel_nxt = wb_dat_i[SCS_CPU_FAST_BIT];
    end
    if (wr && wb_adr_i == SCS_TRIM_ADR && wb_sel_i[0]) begin
      trim_nxt = wb_dat_i[SCS_TRIM_W-1:0];
    end
    if (wr && wb_adr_i == SCS_TICK_DIV_ADR) begin
      tick_div_nxt = lane_merge(tick_div_r, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
    // hardware drops the crystal select; wins over a software write
    if (fail_evt) begin
      main_src_nxt[SCS_XSEL_BIT] = 1'b0;
    end
    // sticky failover flag, write one to clear, a new failure wins
    failover_nxt = fail_evt | (failover_r & ~(wr && wb_adr_i == SCS_STATUS_ADR &&
                                             wb_sel_i[0] && wb_dat_i[SCS_ST_FAILOVER]));
    nmi_nxt      = fail_evt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_src_r <= SCS_MAIN_SRC_RST;
      cpu_sel_r  <= SCS_CPU_SEL_RST;
      trim_r     <= SCS_TRIM_RST;
      tick_div_r <= {SCS_TICK_FRC_RST, SCS_TICK_INT_RST};
      failover_r <= 1'b0;
      nmi_r      <= 1'b0;
      ack_r      <= 1'b0;
      dat_r      <= 32'h0000_0000;
    end else begin
      main_src_r <= main_src_nxt;
      cpu_sel_r  <= cpu_sel_nxt;
      trim_r     <= trim_nxt;
      tick_div_r <= tick_div_nxt;
      failover_r <= failover_nxt;
      nmi_r      <= nmi_nxt;
      ack_r      <= ack_nxt;
      dat_r      <= dat_nxt;
    end
  end

  // system clock switch: park low on the old source, then wait for the new
  // source to be low, so neither period is cut short unless the crystal fails
  scs_sw_t sw_st_r, sw_st_nxt;
  logic    cur_xtal_nxt;
  logic    sys_clk_r, sys_clk_nxt;
  logic    pclk_r, pclk_nxt;
  logic    cpu_sys_nxt;
  logic    cpu_clk_r, cpu_clk_nxt;
  logic    cur_lvl;
  logic    sys_rise;
  logic    want_cpu_sys;

  assign cur_lvl = cur_xtal_r ? xtal_lvl : fast_lvl;

  always_comb begin
    sw_st_nxt    = sw_st_r;
    cur_xtal_nxt = cur_xtal_r;
    sys_clk_nxt  = sys_clk_r;
    case (sw_st_r)
      SCS_SW_FOLLOW: begin
        // a failing crystal is not followed any more, so its last level is not cut to one sample
        sys_clk_nxt = fail_evt ? sys_clk_r : cur_lvl;
        if (want_xtal != cur_xtal_r) begin
          sw_st_nxt = SCS_SW_PARK;
        end
      end
      SCS_SW_PARK: begin
        // a dead crystal may never fall, so let go at once
        sys_clk_nxt = sys_clk_r & cur_lvl & ~fail_evt;
        if (!sys_clk_nxt) begin
          cur_xtal_nxt = want_xtal;
          sw_st_nxt    = SCS_SW_ACQUIRE;
        end
      end
      SCS_SW_ACQUIRE: begin
        // hold low until the new source is low
        sys_clk_nxt = 1'b0;
        // a crystal dying mid-switch may stand high forever: go back to rc
        if (fail_evt) begin
          cur_xtal_nxt = 1'b0;
        end
        if (!cur_lvl) begin
          sw_st_nxt = SCS_SW_FOLLOW;
        end
      end
      default: begin
        sw_st_nxt = SCS_SW_FOLLOW;
      end
    endcase
  end

  assign sys_rise = sys_clk_nxt & ~sys_clk_r;
  // flash forces 12 MHz: sysclk on rc, peripheral clock on crystal
  assign want_cpu_sys = flash_busy_i ? ~cur_xtal_r : cpu_sel_r;

  always_comb begin
    // divide by two on every system rising edge
    pclk_nxt    = sys_rise ? ~pclk_r : pclk_r;
    cpu_sys_nxt = cpu_sys_r;
    // cpu source changes only where both clocks rise together
    if (sys_rise && !pclk_r) begin
      cpu_sys_nxt = want_cpu_sys;
    end
    cpu_clk_nxt = cpu_sys_nxt ? sys_clk_nxt : pclk_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // start on the fast rc oscillator
      sw_st_r    <= SCS_SW_FOLLOW;
      cur_xtal_r <= 1'b0;
      sys_clk_r  <= 1'b0;
      pclk_r     <= 1'b0;
      cpu_sys_r  <= 1'b0;
      cpu_clk_r  <= 1'b0;
    end else begin
      sw_st_r    <= sw_st_nxt;
      cur_xtal_r <= cur_xtal_nxt;
      sys_clk_r  <= sys_clk_nxt;
      pclk_r     <= pclk_nxt;
      cpu_sys_r  <= cpu_sys_nxt;
      cpu_clk_r  <= cpu_clk_nxt;
    end
  end

  // fast rc calibration: count rc edges over a fixed crystal window
  logic [7:0] cal_win_r, cal_win_nxt;
  logic [7:0] cal_cnt_r, cal_cnt_nxt;
  logic [7:0] cal_nxt;

  always_comb begin
    cal_win_nxt = cal_win_r;
    cal_cnt_nxt = cal_cnt_r + 8'(fast_rise);
    cal_nxt     = cal_r;
    if (!xtal_ok) begin
      cal_win_nxt = 8'h00;
      cal_cnt_nxt = 8'h00;
    end else if (xtal_rise) begin
      if (cal_win_r == SCS_CAL_WINDOW - 8'h01) begin
        cal_nxt     = cal_cnt_nxt;
        cal_win_nxt = 8'h00;
        cal_cnt_nxt = 8'h00;
      end else begin
        cal_win_nxt = cal_win_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_win_r <= 8'h00;
      cal_cnt_r <= 8'h00;
      cal_r     <= 8'h00;
    end else begin
      cal_win_r <= cal_win_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      cal_r     <= cal_nxt;
    end
  end

  // millisecond tick: fractional-N divide of the slow rc oscillator;
  // a new ratio takes effect at the next wrap, ratios below 2 are not useful
  logic [7:0] tick_cnt_r, tick_cnt_nxt;
  logic [7:0] tick_acc_r, tick_acc_nxt;
  logic [7:0] tick_tgt_r, tick_tgt_nxt;
  logic       tick_r, tick_nxt;
  logic [8:0] acc_sum;

  assign acc_sum = {1'b0, tick_acc_r} + {1'b0, tick_div_r[SCS_TICK_FRC_LSB +: 8]};

  always_comb begin
    tick_cnt_nxt = tick_cnt_r;
    tick_acc_nxt = tick_acc_r;
    tick_tgt_nxt = tick_tgt_r;
    tick_nxt     = tick_r;
    // no slow edges while the oscillator is off, so the tick holds
    if (slow_rise) begin
      tick_cnt_nxt = tick_cnt_r + 8'h01;
      if (tick_cnt_nxt >= tick_tgt_r) begin
        tick_cnt_nxt = 8'h00;
        tick_acc_nxt = acc_sum[7:0];
        tick_tgt_nxt = tick_div_r[SCS_TICK_INT_LSB +: 8] + 8'(acc_sum[8]);
      end
      tick_nxt = tick_cnt_nxt < (tick_tgt_nxt >> 1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= 8'h00;
      tick_acc_r <= 8'h00;
      tick_tgt_r <= SCS_TICK_INT_RST;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_acc_r <= tick_acc_nxt;
      tick_tgt_r <= tick_tgt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign wb_ack_o                 = ack_r;
  assign wb_dat_o                 = dat_r;
  assign sys_clk_o                = sys_clk_r;
  assign periph_clk_o             = pclk_r;
  assign cpu_clock_o              = cpu_clk_r;
  // ram always runs at system rate: equal to fast cpu, twice the slow one
  assign ram_clk_o                = sys_clk_r;
  // radio usable only on the crystal
  assign radio_clk_ok_o           = cur_xtal_r & (sw_st_r == SCS_SW_FOLLOW);
  // crystal powered by its enable bit
  assign crystal_osc_en_o         = main_src_r[SCS_XEN_BIT];
  assign fast_rc_trim_o           = trim_r;
  assign millisecond_tick_clock_o = tick_r;
  assign watch_crystal_clock_o    = sync2_r[5];
  assign nmi_o                    = nmi_r;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] flash_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !flash_busy_i || cur_xtal_r != cur_xtal_nxt) begin
      flash_cnt_r <= 8'h00;
    end else if (flash_cnt_r != 8'hFF) begin
      flash_cnt_r <= flash_cnt_r + 8'h01;
    end
  end

  chk_reset_clears_sel: assert property (disable iff (1'b0)
    rst_i |=> main_src_r == 2'h0 && !cpu_sel_r && !cur_xtal_r && !sys_clk_r)
    else $error("reset did not clear selects");
  chk_fail_raises_nmi: assert property (fail_evt |=>
    nmi_o && failover_r && !main_src_r[SCS_XSEL_BIT])
    else $error("crystal failure without nmi");
  chk_fail_back_rc: assert property (fail_evt |-> ##[1:4] !cur_xtal_r)
    else $error("no fallback to rc after failure");
  chk_pclk_half_rate: assert property ($changed(pclk_r) == $rose(sys_clk_r))
    else $error("peripheral clock not half of system clock");
  chk_flash_cpu_rate: assert property (flash_cnt_r == 8'h64 |->
    cpu_sys_r == !cur_xtal_r)
    else $error("cpu not at 12 MHz during flash");
  chk_cpu_switch_edge: assert property ($changed(cpu_sys_r) |->
    $rose(sys_clk_r) && pclk_r)
    else $error("cpu source switched off an edge");
  chk_sys_park_low: assert property (sw_st_r == SCS_SW_ACQUIRE |->
    !sys_clk_r ##1 (sw_st_r != SCS_SW_FOLLOW || !sys_clk_r))
    else $error("system clock not held low across switch");
  chk_src_write_lands: assert property (wr && wb_adr_i == SCS_MAIN_SRC_ADR
    && wb_sel_i[0] && !fail_evt |=> main_src_r == $past(wb_dat_i[1:0]))
    else $error("source select write lost");
  chk_xtal_needs_en: assert property ($rose(cur_xtal_r) |->
    $past(main_src_r[SCS_XEN_BIT]) && $past(xtal_ok))
    else $error("crystal taken without enable");
  chk_tick_halts_off: assert property (!slow_on |=> $stable(tick_r))
    else $error("tick moved with slow rc off");

  cov_failover: cover property (fail_evt);
  cov_to_crystal: cover property ($rose(cur_xtal_r));
  cov_flash_xtal: cover property (flash_busy_i && cur_xtal_r && !cpu_sys_r && cpu_sel_r);
  cov_tick_edge: cover property ($rose(tick_r));

endmodule

// File: logic/scs_pkg.sv
// system clock switching: register map, field positions, reset values, rates
// shared by the clock control block and whoever drives its register bus
package scs_pkg;

  // register byte addresses (each register is one aligned 32-bit word)
  localparam logic [31:0] SCS_MAIN_SRC_ADR = 32'h4000_401C;
  localparam logic [31:0] SCS_CPU_SEL_ADR  = 32'h4000_4020;
  localparam logic [31:0] SCS_TRIM_ADR     = 32'h4000_4024;
  localparam logic [31:0] SCS_TICK_DIV_ADR = 32'h4000_4028;
  localparam logic [31:0] SCS_STATUS_ADR   = 32'h4000_402C;
  localparam logic [31:0] SCS_CAL_ADR      = 32'h4000_4030;

  // field positions
  localparam int SCS_XSEL_BIT     = 0;
  localparam int SCS_XEN_BIT      = 1;
  localparam int SCS_CPU_FAST_BIT = 0;
  localparam int SCS_TRIM_W       = 5;
  localparam int SCS_TICK_INT_LSB = 0;
  localparam int SCS_TICK_FRC_LSB = 8;
  localparam int SCS_ST_XTAL_ACT  = 0;
  localparam int SCS_ST_FAILOVER  = 1;
  localparam int SCS_ST_XTAL_OK   = 2;
  localparam int SCS_ST_FLASH_FRC = 3;
  localparam int SCS_ST_CPU_FAST  = 4;

  // reset values
  localparam logic [1:0]            SCS_MAIN_SRC_RST = 2'h0;
  localparam logic                  SCS_CPU_SEL_RST  = 1'h0;
  localparam logic [SCS_TRIM_W-1:0] SCS_TRIM_RST     = 5'h10;
  localparam logic [7:0]            SCS_TICK_FRC_RST = 8'h00;

  // nominal rates
  localparam int SCS_SYS_CLK_HZ   = 125_000_000;
  localparam int SCS_FAST_RC_HZ   = 12_000_000;
  localparam int SCS_CRYSTAL_HZ   = 24_000_000;
  localparam int SCS_SLOW_RC_HZ   = 10_000;
  localparam int SCS_TICK_HZ      = 1_000;
  localparam int SCS_WATCH_HZ     = 32_768;
  localparam int SCS_TRIM_STEP_HZ = 500_000;

  // tick divide ratio out of reset: slow rc edges per millisecond tick
  localparam logic [7:0] SCS_TICK_INT_RST = 8'(SCS_SLOW_RC_HZ / SCS_TICK_HZ);
  // calibration window in crystal rising edges (10 us at the crystal rate)
  localparam logic [7:0] SCS_CAL_WINDOW   = 8'(SCS_CRYSTAL_HZ / 100_000);

  // glitch-free source switch sequencer
  typedef enum logic [1:0] {
    SCS_SW_FOLLOW,
    SCS_SW_PARK,
    SCS_SW_ACQUIRE
  } scs_sw_t;

endpackage

// File: sim/scs_osc_model.sv
// oscillator model for the clock switching block: fast rc, main crystal, slow rc, watch crystal
// assumes the bench scales the slow rc and watch periods down to keep the run short
module scs_osc_model #(
  parameter real SLOW_HALF_NS  = 200.0,
  parameter real WATCH_HALF_NS = 1000.0,
  parameter real XTAL_START_NS = 2000.0
) (
  // controls
  input  wire logic xtal_en_i,
  input  wire logic xtal_fail_i,
  input  wire logic slow_on_i,
  // oscillator levels
  output logic      fast_rc_o,
  output logic      xtal_o,
  output logic      xtal_ok_o,
  output logic      slow_rc_o,
  output logic      watch_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    fast_rc_o = 1'b0;
    forever #41.667 fast_rc_o = ~fast_rc_o;
  end

  // a dead or disabled crystal stands still, it does not keep toggling
  initial begin
    xtal_o = 1'b0;
    forever begin
      #20.833;
      if (xtal_en_i && !xtal_fail_i) xtal_o = ~xtal_o;
    end
  end

  // ok only after start-up time; drops at once on failure
  initial begin
    xtal_ok_o = 1'b0;
    forever begin
      @(xtal_en_i or xtal_fail_i);
      xtal_ok_o = 1'b0;
      if (xtal_en_i && !xtal_fail_i) begin
        #(XTAL_START_NS);
        xtal_ok_o = xtal_en_i && !xtal_fail_i;
      end
    end
  end

  // powered-down slow rc parks low
  initial begin
    slow_rc_o = 1'b0;
    forever begin
      #(SLOW_HALF_NS);
      slow_rc_o = slow_on_i ? ~slow_rc_o : 1'b0;
    end
  end

  initial begin
    watch_o = 1'b0;
    forever #(WATCH_HALF_NS) watch_o = ~watch_o;
  end
endmodule

// File: sim/scs_top_tb.sv
// self-checking bench for the clock switching block
// assumes the oscillator model drives all analog inputs except slow_rc_on_i; rates are judged by edge counts
module scs_top_tb
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i        = 1'b0;
  logic        rst_i        = 1'b1;
  logic        wb_cyc_i     = 1'b0;
  logic        wb_stb_i     = 1'b0;
  logic        wb_we_i      = 1'b0;
  logic [31:0] wb_adr_i     = 32'h0;
  logic [3:0]  wb_sel_i     = 4'hF;
  logic [31:0] wb_dat_i     = 32'h0;
  logic        flash_busy_i = 1'b0;
  logic        slow_rc_on_i = 1'b0;
  logic        xtal_fail    = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, fast_rc_osc_i, main_crystal_osc_i, crystal_ok_i, slow_rc_osc_i;
  logic        watch_crystal_osc_i, sys_clk_o, periph_clk_o, cpu_clock_o, ram_clk_o;
  logic        radio_clk_ok_o, crystal_osc_en_o, millisecond_tick_clock_o;
  logic        watch_crystal_clock_o, nmi_o;
  logic [4:0]  fast_rc_trim_o;
  int          fails        = 0;
  int          checks_done  = 0;
  int          glitch_run   = 2;
  logic        glitch_lvl   = 1'b0;

  scs_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .fast_rc_osc_i, .main_crystal_osc_i, .crystal_ok_i,
    .slow_rc_osc_i, .slow_rc_on_i, .watch_crystal_osc_i, .flash_busy_i, .sys_clk_o,
    .periph_clk_o, .cpu_clock_o, .ram_clk_o, .radio_clk_ok_o, .crystal_osc_en_o,
    .fast_rc_trim_o, .millisecond_tick_clock_o, .watch_crystal_clock_o, .nmi_o);

  scs_osc_model u_osc (.xtal_en_i(crystal_osc_en_o), .xtal_fail_i(xtal_fail),
    .slow_on_i(slow_rc_on_i), .fast_rc_o(fast_rc_osc_i), .xtal_o(main_crystal_osc_i),
    .xtal_ok_o(crystal_ok_i), .slow_rc_o(slow_rc_osc_i), .watch_o(watch_crystal_osc_i));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_near(input int got, input int exp, input int tol);
    checks_done++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // ack comes one cycle after the request is taken
    chk_val(32'(n), 32'h2);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return sys_clk_o;
      1: return periph_clk_o;
      2: return cpu_clock_o;
      3: return ram_clk_o;
      4: return millisecond_tick_clock_o;
      5: return watch_crystal_clock_o;
      default: return nmi_o;
    endcase
  endfunction

  task automatic edges(input int s, input int n, output int cnt);
    logic prev;
    logic cur;
    cnt = 0;
    prev = pick(s);
    repeat (n) begin
      @(posedge clk_i);
      cur = pick(s);
      if (cur === 1'b1 && prev === 1'b0) cnt++;
      prev = cur;
    end
  endtask

  // rising edges in 1000 cycles (8 us): 96 at 12 MHz, 192 at 24 MHz
  task automatic rates(input int es, input int ep, input int ec);
    int c;
    repeat (40) @(posedge clk_i);
    edges(0, 1000, c);
    chk_near(c, es, 2);
    edges(1, 1000, c);
    chk_near(c, ep, 2);
    edges(2, 1000, c);
    chk_near(c, ec, 2);
    edges(3, 1000, c);
    chk_near(c, es, 2);
  endtask

  // a sys clock level lasting one sample would be a runt pulse
  always @(posedge clk_i) begin
    if (!rst_i && sys_clk_o !== glitch_lvl) begin
      chk_near(glitch_run, 500, 498);
      glitch_run = 0;
    end
    glitch_lvl = sys_clk_o;
    glitch_run++;
  end

  task automatic sc_reset_regs();
    wb(1'b0, SCS_MAIN_SRC_ADR, 32'h0);
    chk_val(rd, 32'h0);
    wb(1'b0, SCS_CPU_SEL_ADR, 32'h0);
    chk_val(rd, 32'h0);
    wb(1'b0, SCS_TRIM_ADR, 32'h0);
    chk_val(rd, 32'h10);
    wb(1'b0, 32'h4000_4040, 32'h0);
    chk_val(rd, 32'h0);
    chk_val({31'h0, radio_clk_ok_o}, 32'h0);
  endtask

  task automatic sc_rc_modes();
    rates(96, 48, 48);
    wb(1'b1, SCS_CPU_SEL_ADR, 32'h1);
    rates(96, 48, 96);
    flash_busy_i <= 1'b1;
    wb(1'b1, SCS_CPU_SEL_ADR, 32'h0);
    rates(96, 48, 96);
    @(posedge clk_i);
    flash_busy_i <= 1'b0;
  endtask

  task automatic sc_crystal_modes();
    wb(1'b1, SCS_MAIN_SRC_ADR, 32'h2);
    // the write lands at the ack edge, so look one edge later
    @(posedge clk_i);
    chk_val({31'h0, crystal_osc_en_o}, 32'h1);
    repeat (400) @(posedge clk_i);
    wb(1'b1, SCS_MAIN_SRC_ADR, 32'h3);
    repeat (100) @(posedge clk_i);
    chk_val({31'h0, radio_clk_ok_o}, 32'h1);
    rates(192, 96, 96);
    wb(1'b1, SCS_CPU_SEL_ADR, 32'h1);
    rates(192, 96, 192);
    flash_busy_i <= 1'b1;
    rates(192, 96, 96);
    @(posedge clk_i);
    flash_busy_i <= 1'b0;
    wb(1'b0, SCS_CAL_ADR, 32'h0);
    chk_near(int'(rd), 120, 3);
  endtask

  task automatic sc_failover();
    int c;
    @(posedge clk_i);
    xtal_fail <= 1'b1;
    edges(6, 60, c);
    chk_val(32'(c), 32'h1);
    wb(1'b0, SCS_MAIN_SRC_ADR, 32'h0);
    chk_val(rd, 32'h2);
    rates(96, 48, 96);
    chk_val({31'h0, radio_clk_ok_o}, 32'h0);
    // status: failover seen, cpu on the system clock, crystal neither ok nor in use
    wb(1'b0, SCS_STATUS_ADR, 32'h0);
    chk_val(rd, 32'h12);
    wb(1'b1, SCS_STATUS_ADR, 32'h2);
    wb(1'b0, SCS_STATUS_ADR, 32'h0);
    chk_val(rd, 32'h10);
  endtask

  task automatic sc_trim_tick_watch();
    int c;
    wb(1'b1, SCS_TRIM_ADR, 32'h13);
    @(posedge clk_i);
    chk_val(32'(fast_rc_trim_o), 32'h13);
    slow_rc_on_i <= 1'b1;
    repeat (1000) @(posedge clk_i);
    edges(4, 5000, c);
    chk_near(c, 10, 1);
    // ratio of five and a half: an extra slow edge on every other tick
    wb(1'b1, SCS_TICK_DIV_ADR, 32'h0000_8005);
    repeat (1000) @(posedge clk_i);
    edges(4, 5000, c);
    chk_near(c, 18, 1);
    slow_rc_on_i <= 1'b0;
    repeat (200) @(posedge clk_i);
    edges(4, 2000, c);
    chk_val(32'(c), 32'h0);
    edges(5, 2000, c);
    chk_near(c, 8, 1);
  endtask

  task automatic sc_reset_again();
    wb(1'b1, SCS_MAIN_SRC_ADR, 32'h2);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, SCS_MAIN_SRC_ADR, 32'h0);
    chk_val(rd, 32'h0);
    wb(1'b0, SCS_CPU_SEL_ADR, 32'h0);
    chk_val(rd, 32'h0);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_reset_regs();
    sc_rc_modes();
    sc_crystal_modes();
    sc_failover();
    sc_trim_tick_watch();
    sc_reset_again();
    report_and_stop();
  end

  // the whole sequence needs about 45k cycles
  initial begin
    repeat (80000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end
endmodule
